// ===== logic/gts_pkg.sv
package gts_pkg;
	// -----------------------------------------------------------------
	// register map and fields
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam int CTRL_START   = 0;
	localparam int CTRL_RENDER  = 1;
	localparam int CTRL_STREAM  = 2;
	localparam int CTRL_LIM_LSB = 8;
	localparam int CTRL_ENT_LSB = 16;
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_TOPO_LSB = 4;
	localparam int CMD_FIRST    = 9;
	localparam int CMD_LAST     = 10;
	localparam int CMD_ADV      = 11;
	localparam int CMD_USED     = 12;
	localparam int CMD_BUF_LSB  = 13;
	localparam int CMD_DW_LSB   = 16;
	localparam int CMD_ELEM_LSB = 20;
	localparam int STAT_BUSY    = 8;
	localparam int STAT_GRANT   = 9;
	localparam int STAT_OPEN    = 10;
	localparam int STAT_RET_LSB = 16;
	localparam int STAT_HND_LSB = 24;
	// error bits of the status register
	localparam int ERR_TOPO   = 0;
	localparam int ERR_ORDER  = 1;
	localparam int ERR_RETAIN = 2;
	localparam int ERR_CONFIG = 3;
	localparam int ERR_PRIM   = 4;
	// -----------------------------------------------------------------
	// commands, message kinds, topology codes, reset values
	// -----------------------------------------------------------------
	localparam logic [1:0] OP_VERTEX  = 2'h0;
	localparam logic [1:0] OP_STREAM  = 2'h1;
	localparam logic [1:0] OP_END     = 2'h2;
	localparam logic [1:0] MSG_TURN   = 2'h0;
	localparam logic [1:0] MSG_VSTORE = 2'h1;
	localparam logic [1:0] MSG_STREAM = 2'h2;
	localparam logic [4:0] TOPO_NONE     = 5'h00;
	localparam logic [4:0] TOPO_QUADLIST = 5'h07;
	localparam logic [4:0] TOPO_QUADSTRP = 5'h08;
	localparam logic [4:0] TOPO_LL_ADJ   = 5'h09;
	localparam logic [4:0] TOPO_LS_ADJ   = 5'h0a;
	localparam logic [4:0] TOPO_TL_ADJ   = 5'h0c;
	localparam logic [4:0] TOPO_TS_ADJ   = 5'h0d;
	localparam logic [4:0] TOPO_LINELOOP = 5'h10;
	localparam logic [5:0] MAX_RETAIN    = 6'h20;
	localparam logic [3:0] RST_LIMIT     = 4'h1;
	localparam logic [3:0] STREAM_LIMIT  = 4'h1;
	typedef enum logic [2:0] {
		ST_IDLE, ST_TURN, ST_WAITWB, ST_RUN, ST_SEND
	} gts_state_t;
endpackage

// ===== logic/gts_thread_sequencer.sv
// Functional notes
// RULE1: the stage lets only one thread emit vertex entries at a time
// RULE2: a rendering thread requests its output turn before any vertex
// RULE3: the stage holds the turn writeback until this thread may emit
// RULE4: the stage grants turns in dispatch order
// RULE5: the last vertex-store write before ending is a committed write
// RULE6: only point, line, triangle, polygon and rectangle topologies sent
// RULE7: every vertex carries a sane topology tag and first/last flags
// RULE8: the stage tolerates primitives with too few or many vertices
// RULE9: the stage samples tag and flags only once the handle completes
// RULE10: retained handles never exceed the lesser of 32 and entries
// RULE11: stream output forces the stage thread limit to one
// RULE12: a stream write stores 1 to 4 doublewords, clipped at buffer end
// RULE13: stream target element fits a 16-element structure, 1-4 dwords
// RULE14: stream writes leave gaps between written elements untouched
// RULE15: no start while the stage has zero vertex-store entries
// RULE16: the stage keeps four stream buffer indices
// RULE17: the stage hands the indices in payload register R1 when enabled
// RULE18: stream write targets come from the initial payload indices
// RULE19: the stage advances its indices on request, passed to next thread
// RULE20: the stage reloads indices from a dedicated state command
// RULE21: the thread ends with a write holding end-of-thread and complete
// RULE22: each payload index is an unsigned 32-bit initial value
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
module gts_thread_sequencer (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         payValid,
	input  wire logic [127:0] payIndex,
	input  wire logic [7:0]   payHandle,
	output logic              msgValid,
	input  wire logic         msgReady,
	output logic      [1:0]   msgKind,
	output logic      [7:0]   msgHandle,
	output logic      [4:0]   msgTopology,
	output logic              msgFirst,
	output logic              msgLast,
	output logic              msgComplete,
	output logic              msgAlloc,
	output logic              msgEot,
	output logic              msgUsed,
	output logic              msgCommit,
	output logic      [1:0]   msgBuf,
	output logic      [1:0]   msgDwords,
	output logic      [3:0]   msgElem,
	output logic      [31:0]  msgIndex,
	output logic              msgAdvance,
	input  wire logic         wbValid,
	input  wire logic [7:0]   wbHandle,
	output logic      [3:0]   cfgThreadLimit,
	output logic              cfgStreamEn
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		gts_pkg::gts_state_t state;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        renderEn;
		logic        streamEn;
		logic [3:0]  limit;
		logic [7:0]  entries;
		logic        granted;
		logic        openPrim;
		logic [7:0]  handle;
		logic [5:0]  retained;
		logic [4:0]  err;
		logic [3:0][31:0] idx;
		logic        mValid;
		logic [1:0]  mKind;
		logic [4:0]  mTopo;
		logic        mFirst;
		logic        mLast;
		logic        mCompl;
		logic        mAlloc;
		logic        mEot;
		logic        mUsed;
		logic        mCommit;
		logic [1:0]  mBuf;
		logic [1:0]  mDw;
		logic [3:0]  mElem;
		logic [31:0] mIndex;
		logic        mAdv;
	} gts_regs_t;

	gts_regs_t s_r;
	gts_regs_t s_nxt;
	logic       acc;
	logic [4:0] errSet;
	logic [4:0] errClr;
	logic [5:0] retLimit;
	logic [1:0] op;
	logic [4:0] topo;
	logic [7:0] entNew;

	// topologies that may leave a geometry thread
	function automatic logic topoValid(input logic [4:0] t);
		return !(t inside {gts_pkg::TOPO_NONE, gts_pkg::TOPO_QUADLIST,
			gts_pkg::TOPO_QUADSTRP, gts_pkg::TOPO_LL_ADJ,
			gts_pkg::TOPO_LS_ADJ, gts_pkg::TOPO_TL_ADJ,
			gts_pkg::TOPO_TS_ADJ, gts_pkg::TOPO_LINELOOP});
	endfunction

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	// handle ceiling is the lesser of 32 and the entry count
	assign retLimit = (s_r.entries < {2'h0, gts_pkg::MAX_RETAIN}) ?
		s_r.entries[5:0] : gts_pkg::MAX_RETAIN; // RULE10
	assign op     = pwdata[gts_pkg::CMD_OP_LSB +: 2];
	assign topo   = pwdata[gts_pkg::CMD_TOPO_LSB +: 5];
	assign entNew = pwdata[gts_pkg::CTRL_ENT_LSB +: 8];

	always_comb begin
		s_nxt = s_r;
		acc = psel && penable && !s_r.pready;
		errSet = 5'h00;
		errClr = 5'h00;
		s_nxt.pready = acc;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0;
		// initial indices and handle from the dispatched payload
		if (s_r.state == gts_pkg::ST_IDLE && payValid) begin
			s_nxt.idx = payIndex; // RULE18
			s_nxt.handle = payHandle;
		end
		// message channel progress
		case (s_r.state)
			gts_pkg::ST_TURN: if (msgReady) begin
				s_nxt.mValid = 1'b0;
				s_nxt.state = gts_pkg::ST_WAITWB;
			end
			gts_pkg::ST_WAITWB: if (wbValid) begin
				// stall here until the stage grants our turn
				s_nxt.handle = wbHandle; // RULE3
				s_nxt.retained = s_r.retained + 6'h1;
				s_nxt.granted = 1'b1;
				s_nxt.state = gts_pkg::ST_RUN;
			end
			gts_pkg::ST_SEND: if (msgReady) begin
				s_nxt.mValid = 1'b0;
				if (s_r.mKind == gts_pkg::MSG_VSTORE && s_r.mCompl)
					s_nxt.retained = s_r.retained - 6'h1; // RULE10
				if (s_r.mKind == gts_pkg::MSG_STREAM && s_r.mAdv)
					s_nxt.idx[s_r.mBuf] = s_r.mIndex + 32'h1; // RULE19
				if (s_r.mEot) begin
					s_nxt.granted = 1'b0;
					s_nxt.state = gts_pkg::ST_IDLE;
				end else if (s_r.mAlloc)
					s_nxt.state = gts_pkg::ST_WAITWB;
				else
					s_nxt.state = gts_pkg::ST_RUN;
			end
			default: ;
		endcase
		// register writes
		if (acc && pwrite) begin
			case (paddr)
				gts_pkg::ADDR_CTRL: if (s_r.state != gts_pkg::ST_IDLE)
					s_nxt.pslverr = 1'b1;
				else begin
					s_nxt.renderEn = pwdata[gts_pkg::CTRL_RENDER];
					s_nxt.streamEn = pwdata[gts_pkg::CTRL_STREAM];
					s_nxt.entries = entNew;
					s_nxt.limit = pwdata[gts_pkg::CTRL_LIM_LSB +: 4];
					if (pwdata[gts_pkg::CTRL_STREAM]) begin
						// ordered stream output needs one thread
						s_nxt.limit = gts_pkg::STREAM_LIMIT; // RULE11
						if (pwdata[gts_pkg::CTRL_LIM_LSB +: 4] !=
							gts_pkg::STREAM_LIMIT)
							errSet[gts_pkg::ERR_CONFIG] = 1'b1;
					end
					if (pwdata[gts_pkg::CTRL_START]) begin
						if (entNew == 8'h00)
							errSet[gts_pkg::ERR_CONFIG] = 1'b1; // RULE15
						else if (pwdata[gts_pkg::CTRL_RENDER]) begin
							s_nxt.mValid = 1'b1; // RULE2
							s_nxt.mKind = gts_pkg::MSG_TURN;
							s_nxt.state = gts_pkg::ST_TURN;
						end else begin
							s_nxt.retained = 6'h1;
							s_nxt.state = gts_pkg::ST_RUN;
						end
					end
				end
				gts_pkg::ADDR_CMD: if (s_r.state != gts_pkg::ST_RUN) begin
					s_nxt.pslverr = 1'b1;
					errSet[gts_pkg::ERR_ORDER] = 1'b1;
				end else begin
					s_nxt.mKind = gts_pkg::MSG_VSTORE;
					s_nxt.mTopo = topo;
					s_nxt.mFirst = pwdata[gts_pkg::CMD_FIRST];
					s_nxt.mLast = pwdata[gts_pkg::CMD_LAST];
					s_nxt.mCompl = 1'b1;
					s_nxt.mAlloc = 1'b0;
					s_nxt.mEot = 1'b0;
					s_nxt.mCommit = 1'b0;
					s_nxt.mUsed = pwdata[gts_pkg::CMD_USED];
					s_nxt.mBuf = pwdata[gts_pkg::CMD_BUF_LSB +: 2];
					s_nxt.mDw = pwdata[gts_pkg::CMD_DW_LSB +: 2];
					s_nxt.mElem = pwdata[gts_pkg::CMD_ELEM_LSB +: 4];
					s_nxt.mAdv = pwdata[gts_pkg::CMD_ADV];
					s_nxt.mIndex = s_r.idx[pwdata[gts_pkg::CMD_BUF_LSB +: 2]];
					unique case (op)
						gts_pkg::OP_VERTEX:
						if (!s_r.renderEn || !s_r.granted) begin
							s_nxt.pslverr = 1'b1;
							errSet[gts_pkg::ERR_ORDER] = 1'b1; // RULE2
						end else if (!topoValid(topo)) begin
							s_nxt.pslverr = 1'b1;
							errSet[gts_pkg::ERR_TOPO] = 1'b1; // RULE6
						end else if (s_r.retained == 6'h0 ||
							s_r.retained > retLimit) begin
							s_nxt.pslverr = 1'b1;
							errSet[gts_pkg::ERR_RETAIN] = 1'b1; // RULE10
						end else begin
							// vertex completes now and fetches the next handle
							s_nxt.mAlloc = 1'b1;
							s_nxt.mValid = 1'b1;
							s_nxt.state = gts_pkg::ST_SEND;
							if (!pwdata[gts_pkg::CMD_FIRST] && !s_r.openPrim)
								errSet[gts_pkg::ERR_PRIM] = 1'b1; // RULE7
							if (pwdata[gts_pkg::CMD_FIRST])
								s_nxt.openPrim = 1'b1;
							if (pwdata[gts_pkg::CMD_LAST])
								s_nxt.openPrim = 1'b0;
						end
						gts_pkg::OP_STREAM: if (!s_r.streamEn) begin
							s_nxt.pslverr = 1'b1;
							errSet[gts_pkg::ERR_CONFIG] = 1'b1;
						end else begin
							// element and dword count fields cap the target
							s_nxt.mKind = gts_pkg::MSG_STREAM; // RULE13
							s_nxt.mValid = 1'b1;
							s_nxt.state = gts_pkg::ST_SEND;
						end
						gts_pkg::OP_END: begin
							if (s_r.openPrim)
								errSet[gts_pkg::ERR_PRIM] = 1'b1; // RULE7
							s_nxt.openPrim = 1'b0;
							s_nxt.mEot = 1'b1; // RULE21
							s_nxt.mCommit = 1'b1; // RULE5
							s_nxt.mValid = 1'b1;
							s_nxt.state = gts_pkg::ST_SEND;
						end
						default: begin
							s_nxt.pslverr = 1'b1;
							errSet[gts_pkg::ERR_ORDER] = 1'b1;
						end
					endcase
				end
				gts_pkg::ADDR_STAT: errClr = pwdata[4:0];
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		// register reads
		if (acc && !pwrite) begin
			case (paddr)
				gts_pkg::ADDR_CTRL: s_nxt.prdata = {8'h0, s_r.entries,
					4'h0, s_r.limit, 5'h0, s_r.streamEn, s_r.renderEn, 1'b0};
				gts_pkg::ADDR_STAT: s_nxt.prdata = {s_r.handle, 2'h0,
					s_r.retained, 5'h0, s_r.openPrim, s_r.granted,
					s_r.state != gts_pkg::ST_IDLE, 3'h0, s_r.err};
				gts_pkg::ADDR_CMD: s_nxt.prdata = 32'h0;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		// a new error wins over a clear in the same cycle
		s_nxt.err = (s_r.err & ~errClr) | errSet;
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.state <= gts_pkg::ST_IDLE;
			s_r.limit <= gts_pkg::RST_LIMIT;
		end else
			s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign msgValid = s_r.mValid;
	assign msgKind = s_r.mKind;
	assign msgHandle = s_r.handle;
	assign msgTopology = s_r.mTopo;
	assign msgFirst = s_r.mFirst;
	assign msgLast = s_r.mLast;
	assign msgComplete = s_r.mCompl;
	assign msgAlloc = s_r.mAlloc;
	assign msgEot = s_r.mEot;
	assign msgUsed = s_r.mUsed;
	assign msgCommit = s_r.mCommit;
	assign msgBuf = s_r.mBuf;
	assign msgDwords = s_r.mDw; // RULE12
	assign msgElem = s_r.mElem;
	assign msgIndex = s_r.mIndex;
	assign msgAdvance = s_r.mAdv;
	assign cfgThreadLimit = s_r.limit;
	assign cfgStreamEn = s_r.streamEn; // RULE17

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic        vtxMsg;
	logic [31:0] curIdx;
	assign vtxMsg = msgValid && msgKind == gts_pkg::MSG_VSTORE && !msgEot;
	assign curIdx = s_r.idx[s_r.mBuf];

	msg_hold_a: assert property (msgValid && !msgReady |=>
		msgValid && $stable(msgKind) && $stable(msgIndex))
		else $error("message dropped before accept");
	turn_first_a: assert property (vtxMsg |-> s_r.granted) // RULE2
		else $error("vertex sent without output turn");
	turn_req_a: assert property ($rose(s_r.state == gts_pkg::ST_TURN)
		|-> msgValid && msgKind == gts_pkg::MSG_TURN) // RULE2
		else $error("turn request not issued");
	commit_end_a: assert property (msgValid && msgEot |-> msgCommit) // RULE5
		else $error("final write not committed");
	eot_bits_a: assert property (msgValid && msgEot |-> msgComplete &&
		msgKind == gts_pkg::MSG_VSTORE && !msgAlloc) // RULE21
		else $error("end write lacks complete");
	topo_ok_a: assert property (vtxMsg |-> topoValid(msgTopology)) // RULE6
		else $error("invalid topology emitted");
	prim_flag_a: assert property (acc && pwrite &&
		paddr == gts_pkg::ADDR_CMD && s_r.state == gts_pkg::ST_RUN &&
		op == gts_pkg::OP_END && s_r.openPrim
		|=> s_r.err[gts_pkg::ERR_PRIM]) // RULE7
		else $error("open primitive not flagged");
	retain_cap_a: assert property (s_r.retained <= retLimit) // RULE10
		else $error("retained handles over limit");
	one_thread_a: assert property (cfgStreamEn |->
		cfgThreadLimit == gts_pkg::STREAM_LIMIT) // RULE11
		else $error("stream with thread limit not one");
	no_entries_a: assert property (s_r.state != gts_pkg::ST_IDLE |->
		s_r.entries != 8'h00) // RULE15
		else $error("started with no entries");
	idx_step_a: assert property (s_r.state == gts_pkg::ST_SEND && msgReady
		&& msgKind == gts_pkg::MSG_STREAM && msgAdvance |=>
		s_r.idx[$past(s_r.mBuf)] == $past(curIdx) + 32'h1) // RULE19
		else $error("stream index not advanced");
	turn_cov: cover property (s_r.state == gts_pkg::ST_WAITWB && wbValid);
	stream_cov: cover property (msgValid && msgReady &&
		msgKind == gts_pkg::MSG_STREAM);
	end_cov: cover property (msgValid && msgReady && msgEot);
endmodule

// ===== tb/gts_stage_model.sv
`timescale 1ns/1ns
module gts_stage_model (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         slow,
	input  wire logic         dispatch,
	input  wire logic         loadEn,
	input  wire logic [127:0] loadVal,
	input  wire logic         streamEn,
	input  wire logic         msgValid,
	output logic              msgReady,
	input  wire logic [1:0]   msgKind,
	input  wire logic         msgAlloc,
	input  wire logic         msgEot,
	input  wire logic [1:0]   msgBuf,
	input  wire logic         msgAdvance,
	output logic              wbValid,
	output logic      [7:0]   wbHandle,
	output logic              payValid,
	output logic      [127:0] payIndex,
	output logic      [7:0]   payHandle
);
	typedef struct packed {
		logic         rdy;
		logic         wbPend;
		logic [1:0]   wbDly;
		logic         wbV;
		logic [7:0]   wbH;
		logic [7:0]   nextH;
		logic         payV;
		logic [7:0]   payH;
		logic [127:0] idx;
		logic [127:0] pay;
	} gts_stage_t;
	gts_stage_t state_r;
	gts_stage_t state_nxt;
	logic       take;

	// --------------------------------------------------------------
	// stage side of the message channel
	// --------------------------------------------------------------
	// one writeback at a time, handed out in the order requests arrive
	always_comb begin
		state_nxt = state_r;
		take = msgValid & state_r.rdy;
		state_nxt.rdy = slow ? ~state_r.rdy : 1'b1;
		state_nxt.wbV = 1'b0;
		state_nxt.payV = 1'b0;
		state_nxt.wbH = ~state_r.wbH; // released lines do not hold
		state_nxt.payH = ~state_r.payH;
		state_nxt.pay = ~state_r.pay;
		if (take && (msgKind == gts_pkg::MSG_TURN || (msgKind ==
			gts_pkg::MSG_VSTORE && msgAlloc && !msgEot))) begin
			state_nxt.wbPend = 1'b1;
			state_nxt.wbDly = slow ? 2'h3 : 2'h0;
		end
		// only the index moves: gaps between written elements stay as they are
		if (take && msgKind == gts_pkg::MSG_STREAM && msgAdvance) begin
			state_nxt.idx[{msgBuf, 5'h00} +: 32] =
				state_r.idx[{msgBuf, 5'h00} +: 32] + 32'h1;
		end
		if (state_r.wbPend) begin
			if (state_r.wbDly == 2'h0) begin
				state_nxt.wbPend = 1'b0;
				state_nxt.wbV = 1'b1;
				state_nxt.wbH = state_r.nextH;
				state_nxt.nextH = state_r.nextH + 8'h1;
			end else begin
				state_nxt.wbDly = state_r.wbDly - 2'h1;
			end
		end
		if (loadEn) begin
			state_nxt.idx = loadVal;
		end
		if (dispatch) begin
			state_nxt.payV = 1'b1;
			state_nxt.payH = state_r.nextH;
			state_nxt.nextH = state_r.nextH + 8'h1;
			state_nxt.pay = streamEn ? state_r.idx : 128'h0;
		end
		if (rst) begin
			state_nxt = '0;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		state_r <= state_nxt;
	end

	// outputs straight from the state
	assign msgReady = state_r.rdy;
	assign wbValid = state_r.wbV;
	assign wbHandle = state_r.wbH;
	assign payValid = state_r.payV;
	assign payHandle = state_r.payH;
	assign payIndex = state_r.pay;
endmodule

// ===== tb/gts_thread_sequencer_tb_top.sv
`timescale 1ns/1ns
module gts_thread_sequencer_tb_top;
	typedef struct packed {
		logic [4:0] topo;
		logic       bad;
	} gts_row_t;
	logic         ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]   paddr, payHandle, msgHandle, wbHandle, accStream;
	logic [7:0]   lastWb, accHandle, expH;
	logic [31:0]  pwdata, prdata, msgIndex, rdata, accIdx;
	logic [127:0] payIndex, loadVal;
	logic         payValid, msgValid, msgReady, msgFirst, msgLast;
	logic         msgComplete, msgAlloc, msgEot, msgUsed, msgCommit;
	logic         msgAdvance, wbValid, cfgStreamEn, slow, dispatch, loadEn;
	logic         rerr;
	logic [1:0]   msgKind, msgBuf, msgDwords, accKind;
	logic [4:0]   msgTopology, accTopo;
	logic [3:0]   msgElem, cfgThreadLimit, accMisc;
	logic [2:0]   accFlags;
	int           accCnt, wbCnt, mismatches, comparisons, a, w;
	gts_row_t     rows [12] = '{'{gts_pkg::TOPO_NONE, 1'b1},
		'{gts_pkg::TOPO_QUADLIST, 1'b1}, '{gts_pkg::TOPO_QUADSTRP, 1'b1},
		'{gts_pkg::TOPO_LL_ADJ, 1'b1}, '{gts_pkg::TOPO_LS_ADJ, 1'b1},
		'{gts_pkg::TOPO_TL_ADJ, 1'b1}, '{gts_pkg::TOPO_TS_ADJ, 1'b1},
		'{gts_pkg::TOPO_LINELOOP, 1'b1}, '{5'h01, 1'b0}, '{5'h04, 1'b0},
		'{5'h06, 1'b0}, '{5'h11, 1'b0}};

	gts_thread_sequencer gts_thread_sequencer_i (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .payValid(payValid),
		.payIndex(payIndex), .payHandle(payHandle), .msgValid(msgValid),
		.msgReady(msgReady), .msgKind(msgKind), .msgHandle(msgHandle),
		.msgTopology(msgTopology), .msgFirst(msgFirst), .msgLast(msgLast),
		.msgComplete(msgComplete), .msgAlloc(msgAlloc), .msgEot(msgEot),
		.msgUsed(msgUsed), .msgCommit(msgCommit), .msgBuf(msgBuf),
		.msgDwords(msgDwords), .msgElem(msgElem), .msgIndex(msgIndex),
		.msgAdvance(msgAdvance), .wbValid(wbValid), .wbHandle(wbHandle),
		.cfgThreadLimit(cfgThreadLimit), .cfgStreamEn(cfgStreamEn));

	gts_stage_model gts_stage_model_i (
		.ref_clk(ref_clk), .rst(rst), .slow(slow), .dispatch(dispatch),
		.loadEn(loadEn), .loadVal(loadVal), .streamEn(cfgStreamEn),
		.msgValid(msgValid), .msgReady(msgReady), .msgKind(msgKind),
		.msgAlloc(msgAlloc), .msgEot(msgEot), .msgBuf(msgBuf),
		.msgAdvance(msgAdvance), .wbValid(wbValid), .wbHandle(wbHandle),
		.payValid(payValid), .payIndex(payIndex), .payHandle(payHandle));

	// --------------------------------------------------------------
	// clock, watchdog and channel monitor
	// --------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// cut a hang short
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end

	// record every accepted message and every writeback
	always @(posedge ref_clk) begin
		if (msgValid && msgReady) begin
			accCnt <= accCnt + 1;
			accKind <= msgKind;
			accTopo <= msgTopology;
			accFlags <= {msgComplete, msgEot, msgCommit};
			accMisc <= {msgFirst, msgLast, msgUsed, msgAlloc};
			accHandle <= msgHandle;
			accIdx <= msgIndex;
			accStream <= {msgBuf, msgDwords, msgElem};
		end
		if (wbValid) begin
			wbCnt <= wbCnt + 1;
			lastWb <= wbHandle;
		end
	end

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	// one bus transfer, held until the slave answers
	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		rerr = pslverr;
		chk(n < 50, "bus answer missing");
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic waitFor(ref int cnt, input int n);
		int k;
		k = 0;
		while (cnt < n && k < 100) begin
			@(negedge ref_clk);
			k++;
		end
		chk(cnt >= n, "message wait ran out");
	endtask

	// one-cycle strobe: index load when ld is set, dispatch otherwise
	task automatic pulse(input logic ld);
		@(posedge ref_clk);
		if (ld)
			loadEn <= 1'b1;
		else
			dispatch <= 1'b1;
		@(posedge ref_clk);
		loadEn <= 1'b0;
		dispatch <= 1'b0;
	endtask

	// end the thread and check the final committed write
	task automatic endThread();
		a = accCnt;
		apb(1'b1, gts_pkg::ADDR_CMD, 32'h2);
		waitFor(accCnt, a + 1);
		chk(accKind === gts_pkg::MSG_VSTORE && accFlags === 3'b111 &&
			accMisc === 4'h0, "end write fields");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{slow, dispatch, loadEn} = '0;
		loadVal = {32'h30, 32'h20, 32'h10, 32'h07fffffe};
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk(cfgThreadLimit === 4'h1 && msgValid === 1'b0, "reset outputs");
		apb(1'b0, 8'h0c, 32'h0);
		chk(rerr === 1'b1, "unmapped read not refused");
		apb(1'b1, gts_pkg::ADDR_CMD, 32'h0);
		apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
		chk(rdata[gts_pkg::ERR_ORDER] === 1'b1, "command while idle");
		apb(1'b1, gts_pkg::ADDR_STAT, 32'h1f);
		apb(1'b1, gts_pkg::ADDR_CTRL, 32'h3);
		apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
		chk(rdata[gts_pkg::ERR_CONFIG] === 1'b1 && accCnt == 0,
			"start without entries");
		apb(1'b1, gts_pkg::ADDR_STAT, 32'h1f);
		// render thread: render, limit 2, four entries
		pulse(1'b0);
		slow <= 1'b1;
		apb(1'b1, gts_pkg::ADDR_CTRL, 32'h00040203);
		waitFor(accCnt, 1);
		chk(accKind === gts_pkg::MSG_TURN, "turn request first");
		waitFor(wbCnt, 1);
		apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
		chk(rdata[gts_pkg::STAT_GRANT] === 1'b1 && rdata[31:24] === lastWb
			&& rdata[21:16] === 6'h01, "turn granted");
		for (int i = 0; i < 12; i++) begin
			a = accCnt;
			w = wbCnt;
			expH = lastWb;
			slow <= i[0];
			apb(1'b1, gts_pkg::ADDR_CMD, (32'(rows[i].topo) << 4) | 32'h1600);
			if (rows[i].bad) begin
				apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
				chk(rdata[gts_pkg::ERR_TOPO] === 1'b1 && accCnt == a,
					"bad topology sent");
				apb(1'b1, gts_pkg::ADDR_STAT, 32'h1f);
			end else begin
				waitFor(accCnt, a + 1);
				waitFor(wbCnt, w + 1);
				chk(accTopo === rows[i].topo && accFlags[2] === 1'b1 &&
					accMisc === 4'hf && accHandle === expH,
					"vertex fields");
			end
		end
		// leave a primitive open: first flag only, then end the thread
		a = accCnt;
		w = wbCnt;
		apb(1'b1, gts_pkg::ADDR_CMD, 32'h1210);
		waitFor(accCnt, a + 1);
		waitFor(wbCnt, w + 1);
		apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
		chk(rdata[gts_pkg::STAT_OPEN] === 1'b1, "primitive not open");
		endThread();
		apb(1'b0, gts_pkg::ADDR_STAT, 32'h0);
		chk(rdata[gts_pkg::STAT_GRANT] === 1'b0 && rdata[21:16] === 6'h00
			&& rdata[gts_pkg::ERR_PRIM] === 1'b1,
			"turn released");
		// stream threads: stream, limit 1, four entries
		pulse(1'b1);
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, gts_pkg::ADDR_CTRL, 32'h00040104);
			chk(cfgStreamEn === 1'b1 && cfgThreadLimit === 4'h1,
				"stream config");
			pulse(1'b0);
			apb(1'b1, gts_pkg::ADDR_CTRL, 32'h00040105);
			for (int b = 0; b < 4; b++) begin
				a = accCnt;
				apb(1'b1, gts_pkg::ADDR_CMD, 32'h801 | (32'(b) << 13) |
					(32'(b) << 16) | (32'(15 - b) << 20));
				waitFor(accCnt, a + 1);
				chk(accIdx === loadVal[b * 32 +: 32] + 32'(p) && accStream ===
					{2'(b), 2'(b), 4'(15 - b)}, "stream write");
			end
			endThread();
		end
		print_verdict();
	end
endmodule
